// >>> src/etc_core.sv
// event transfer controller: apb registers and transfer engine
//
// Implementation choices: the register offsets and the APB register port.
module etc_core (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic standby_in,
  input wire logic nmi_in,
  input wire etc_pkg::etc_apb_s apb_in,
  output logic pready_out,
  output logic pslverr_out,
  output logic [31:0] prdata_out,
  input wire logic [39:0] src_req_in,
  output logic [39:0] src_ack_out,
  output etc_pkg::etc_mem_s mem_out,
  input wire logic mem_ack_in,
  input wire logic mem_err_in,
  input wire logic [31:0] mem_rdata_in,
  output logic busy_out
);
  etc_pkg::etc_state_s st;
  etc_pkg::etc_state_s next_st;
  logic [15:0] info_base;
  logic acc;
  logic wr;
  logic rd;
  logic mapped;
  logic [31:0] rd_value;
  logic done;
  logic err;
  logic ok;
  logic [39:0] avail;
  logic [5:0] pick;
  logic sw_go;
  logic [15:0] vec_addr;
  logic stop;

  // enable register slot for an address, 3'h7 when not one
  function automatic logic [2:0] en_slot(input logic [7:0] a);
    if (a[1:0] == 2'h0 && a <= etc_pkg::OFS_EN_LAST) begin
      return 3'h4 - a[4:2];
    end
    return 3'h7;
  endfunction

  // bit takes the written value only where it differs from the last read
  function automatic logic [7:0] merge(input logic [7:0] cur, input logic [7:0] w,
                                       input logic [7:0] seen);
    return (cur & ~(w ^ seen)) | (w & (w ^ seen));
  endfunction

  // address step after a unit
  function automatic logic [31:0] adj(input logic [31:0] a, input logic [1:0] am,
                                      input logic [1:0] sz);
    logic [31:0] step;
    step = (sz == etc_pkg::SZ_LONG) ? 32'h4 : (sz == etc_pkg::SZ_WORD) ? 32'h2 : 32'h1;
    if (!am[1]) begin
      return a;
    end
    return am[0] ? a - step : a + step;
  endfunction

  // highest numbered pending source wins
  function automatic logic [5:0] top_of(input logic [39:0] v);
    logic [5:0] r;
    r = 6'h0;
    for (int i = 0; i < 40; i++) begin
      if (v[i]) begin
        r = 6'(i);
      end
    end
    return r;
  endfunction

  // apb decode; zero wait states, data prepared in the setup cycle
  assign acc = apb_in.psel && apb_in.penable;
  assign wr = acc && apb_in.pwrite;
  assign rd = acc && !apb_in.pwrite;
  assign mapped = en_slot(apb_in.paddr) != 3'h7 || apb_in.paddr == etc_pkg::OFS_CSR ||
                  apb_in.paddr == etc_pkg::OFS_BASE;
  assign pready_out = acc;
  assign pslverr_out = acc && !mapped;
  assign prdata_out = st.prdata;
  assign mem_out = st.mem;
  assign busy_out = st.fsm != etc_pkg::S_IDLE;

  // read data mux
  always_comb begin
    rd_value = 32'h0;
    if (en_slot(apb_in.paddr) != 3'h7) begin
      rd_value = {24'h0, st.en[en_slot(apb_in.paddr)]};
    end else if (apb_in.paddr == etc_pkg::OFS_CSR) begin
      rd_value = {21'h0, st.nmi, st.ae, st.swde, st.vec};
    end else if (apb_in.paddr == etc_pkg::OFS_BASE) begin
      rd_value = {16'h0, info_base};
    end
  end

  // memory handshake and request arbitration
  assign done = st.mem.req && mem_ack_in && !mem_err_in;
  assign err = st.mem.req && mem_ack_in && mem_err_in;
  assign ok = st.fsm == etc_pkg::S_IDLE && !st.nmi && !st.ae && !standby_in;
  assign avail = ok ? (src_req_in & st.en) : 40'h0;
  assign pick = top_of(avail);
  assign src_ack_out = (avail != 40'h0) ? (40'h1 << pick) : 40'h0;
  assign sw_go = ok && avail == 40'h0 && st.swde;
  assign vec_addr = sw_go ? etc_pkg::VEC_BASE + {8'h0, st.vec} :
                    etc_pkg::VEC_BASE + {9'h0, etc_pkg::SRC_TOP - pick, 1'b0};
  assign stop = st.nmi && !st.mode[etc_pkg::MODE_CONTINUE_ON_NMI];

  // next state
  always_comb begin
    logic unit_end;
    logic [2:0] slot;
    unit_end = 1'b1;
    slot = en_slot(apb_in.paddr);
    next_st = st;
    if (apb_in.psel && !apb_in.penable) begin
      next_st.prdata = rd_value;
    end
    case (st.fsm)
      etc_pkg::S_IDLE: begin
        if (avail != 40'h0 || sw_go) begin
          next_st.fsm = etc_pkg::S_VEC;
          next_st.sw_run = sw_go;
          next_st.mem = '{req: 1'b1, we: 1'b0, size: etc_pkg::SZ_WORD,
                          addr: {16'h0, vec_addr}, wdata: 32'h0};
        end
      end
      etc_pkg::S_VEC: begin
        if (done) begin
          next_st.info_addr = {info_base, mem_rdata_in[15:0]};
          next_st.widx = 2'h0;
          next_st.fsm = etc_pkg::S_FETCH;
          next_st.mem.size = etc_pkg::SZ_LONG;
          next_st.mem.addr = {info_base, mem_rdata_in[15:0]};
        end
      end
      etc_pkg::S_FETCH: begin
        if (done) begin
          case (st.widx)
            2'h0: {next_st.mode, next_st.cra} = mem_rdata_in;
            2'h1: next_st.sar = mem_rdata_in;
            2'h2: next_st.dar = mem_rdata_in;
            default: next_st.iar = mem_rdata_in;
          endcase
          next_st.widx = st.widx + 2'h1;
          next_st.mem.addr = st.info_addr + {28'h0, st.widx + 2'h1, 2'h0};
          if (st.widx == 2'h3) begin
            next_st.blk_left = {mem_rdata_in[15:0] == 16'h0, mem_rdata_in[15:0]};
            next_st.fsm = etc_pkg::S_XREAD;
            next_st.mem.size = st.mode[etc_pkg::MODE_SZ +: 2];
            next_st.mem.addr = st.sar;
          end
        end
      end
      etc_pkg::S_XREAD: begin
        if (done) begin
          next_st.dbuf = mem_rdata_in;
          next_st.fsm = etc_pkg::S_XWRITE;
          next_st.mem.we = 1'b1;
          next_st.mem.addr = st.dar;
          next_st.mem.wdata = mem_rdata_in;
        end
      end
      etc_pkg::S_XWRITE: begin
        if (done) begin
          next_st.sar = adj(st.sar, st.mode[etc_pkg::MODE_SM +: 2],
                            st.mode[etc_pkg::MODE_SZ +: 2]);
          next_st.dar = adj(st.dar, st.mode[etc_pkg::MODE_DM +: 2],
                            st.mode[etc_pkg::MODE_SZ +: 2]);
          case (st.mode[etc_pkg::MODE_MD +: 2])
            etc_pkg::MD_NORMAL: next_st.cra = st.cra - 16'h1;
            etc_pkg::MD_REPEAT: begin
              if (st.cra[7:0] == 8'h01) begin
                next_st.cra[7:0] = st.cra[15:8];
                if (st.mode[etc_pkg::MODE_DTS]) begin
                  next_st.sar = st.iar;
                end else begin
                  next_st.dar = st.iar;
                end
              end else begin
                next_st.cra[7:0] = st.cra[7:0] - 8'h01;
              end
            end
            etc_pkg::MD_BLOCK: begin
              next_st.blk_left = st.blk_left - 17'h1;
              if (st.blk_left != 17'h1 && !stop) begin
                unit_end = 1'b0;
              end else begin
                next_st.cra = st.cra - 16'h1;
              end
            end
            default: next_st.cra = st.cra;
          endcase
          if (unit_end) begin
            next_st.fsm = etc_pkg::S_WBACK;
            next_st.widx = 2'h0;
            next_st.mem.size = etc_pkg::SZ_LONG;
            next_st.mem.addr = st.info_addr;
            next_st.mem.wdata = {st.mode, next_st.cra};
          end else begin
            next_st.fsm = etc_pkg::S_XREAD;
            next_st.mem.we = 1'b0;
            next_st.mem.addr = next_st.sar;
          end
        end
      end
      etc_pkg::S_WBACK: begin
        if (done) begin
          next_st.widx = st.widx + 2'h1;
          next_st.mem.addr = st.info_addr + {28'h0, st.widx + 2'h1, 2'h0};
          case (st.widx)
            2'h0: next_st.mem.wdata = st.sar;
            2'h1: next_st.mem.wdata = st.dar;
            default: next_st.mem.wdata = st.iar;
          endcase
          if (st.widx == 2'h3) begin
            if (st.mode[etc_pkg::MODE_CHAIN_ENABLE] && !st.nmi && !st.ae) begin
              next_st.fsm = etc_pkg::S_FETCH;
              next_st.widx = 2'h0;
              next_st.info_addr = st.info_addr + etc_pkg::INFO_STRIDE;
              next_st.mem.we = 1'b0;
              next_st.mem.addr = st.info_addr + etc_pkg::INFO_STRIDE;
            end else begin
              next_st.fsm = etc_pkg::S_IDLE;
              next_st.mem.req = 1'b0;
              next_st.mem.we = 1'b0;
              if (st.sw_run && !st.mode[etc_pkg::MODE_DISEL]) begin
                next_st.swde = 1'b0;
              end
            end
          end
        end
      end
      default: next_st.fsm = etc_pkg::S_IDLE;
    endcase
    if (err) begin
      next_st.fsm = etc_pkg::S_IDLE;
      next_st.mem.req = 1'b0;
      next_st.mem.we = 1'b0;
    end
    // last-read snapshots
    if (rd && slot != 3'h7) begin
      next_st.en_seen[slot] = st.en[slot];
    end
    if (rd && apb_in.paddr == etc_pkg::OFS_CSR) begin
      next_st.csr_seen = {st.nmi, st.ae, st.swde};
    end
    if (wr && slot != 3'h7) begin
      next_st.en[slot] = merge(st.en[slot], apb_in.pwdata[7:0], st.en_seen[slot]);
    end
    if (wr && apb_in.paddr == etc_pkg::OFS_CSR) begin
      if (!apb_in.pwdata[etc_pkg::BIT_NMI] && st.csr_seen[2]) begin
        next_st.nmi = 1'b0;
      end
      if (!apb_in.pwdata[etc_pkg::BIT_AE] && st.csr_seen[1]) begin
        next_st.ae = 1'b0;
      end
      if (apb_in.pwdata[etc_pkg::BIT_SWDE]) begin
        next_st.swde = 1'b1;
      end else if (st.csr_seen[0]) begin
        next_st.swde = 1'b0;
      end
      if (!st.swde) begin
        next_st.vec = apb_in.pwdata[7:0];
      end
    end
    // hardware sets win over software clears; standby clears win over both
    if (nmi_in) begin
      next_st.nmi = 1'b1;
    end
    if (err) begin
      next_st.ae = 1'b1;
    end
    if (standby_in) begin
      next_st.en = '0;
      next_st.en_seen = '0;
      next_st.nmi = 1'b0;
      next_st.ae = 1'b0;
      next_st.swde = 1'b0;
      next_st.vec = etc_pkg::VEC_RESET;
      next_st.csr_seen = 3'h0;
    end
  end

  // state register
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st <= '0;
      st.fsm <= etc_pkg::S_IDLE;
      st.en <= {5{etc_pkg::EN_RESET}};
      st.vec <= etc_pkg::VEC_RESET;
    end else begin
      st <= next_st;
    end
  end

  always_ff @(posedge clk_in) begin
    if (wr && apb_in.paddr == etc_pkg::OFS_BASE) begin
      info_base <= apb_in.pwdata[15:0];
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  logic nmi_clr_ok;
  logic unit_wr;
  logic chain_go;
  assign nmi_clr_ok = wr && apb_in.paddr == etc_pkg::OFS_CSR &&
                      !apb_in.pwdata[etc_pkg::BIT_NMI] && st.csr_seen[2];
  assign unit_wr = st.fsm == etc_pkg::S_XWRITE && done;
  assign chain_go = st.fsm == etc_pkg::S_WBACK && done && st.widx == 2'h3 &&
                    st.mode[etc_pkg::MODE_CHAIN_ENABLE] && !st.nmi && !st.ae;

  sequence s_unit_done;
    unit_wr && st.mode[etc_pkg::MODE_MD +: 2] != etc_pkg::MD_BLOCK;
  endsequence
  sequence s_writeback;
    st.fsm == etc_pkg::S_WBACK && st.mem.we && st.mem.addr == st.info_addr;
  endsequence

  a_nmi_blocks_start: assert property ((st.fsm == etc_pkg::S_IDLE && st.nmi) |=>
    st.fsm == etc_pkg::S_IDLE) else $error("start while nmi flag set");
  a_ae_blocks_start: assert property ((st.fsm == etc_pkg::S_IDLE && st.ae) |=>
    st.fsm == etc_pkg::S_IDLE) else $error("start while address error set");
  a_nmi_flag_clear: assert property ($fell(st.nmi) |->
    $past(nmi_clr_ok) || $past(standby_in)) else $error("nmi flag cleared wrongly");
  a_swde_write_one: assert property ((wr && apb_in.paddr == etc_pkg::OFS_CSR &&
    apb_in.pwdata[etc_pkg::BIT_SWDE] && !standby_in) |=> st.swde)
    else $error("software enable write of 1 lost");
  a_vec_locked: assert property ((wr && apb_in.paddr == etc_pkg::OFS_CSR && st.swde &&
    !standby_in) |=> $stable(st.vec)) else $error("vector written while enabled");
  a_source_gated: assert property ((src_ack_out != 40'h0) |->
    (src_ack_out & st.en) == src_ack_out && $onehot(src_ack_out))
    else $error("disabled source accepted");
  a_standby_enables: assert property (standby_in |=> st.en == '0)
    else $error("standby left enables set");
  a_standby_status: assert property (standby_in && !nmi_in |=>
    {st.nmi, st.ae, st.swde, st.vec} == 11'h0) else $error("standby left status set");
  a_sw_vector_addr: assert property (sw_go |=>
    st.mem.addr == {16'h0, etc_pkg::VEC_BASE + {8'h0, st.vec}})
    else $error("software vector address wrong");
  a_normal_count: assert property ((unit_wr &&
    st.mode[etc_pkg::MODE_MD +: 2] == etc_pkg::MD_NORMAL) |=> st.cra == $past(st.cra) - 16'h1)
    else $error("normal count not decremented");
  a_repeat_reload: assert property ((unit_wr && st.cra[7:0] == 8'h01 &&
    st.mode[etc_pkg::MODE_MD +: 2] == etc_pkg::MD_REPEAT) |=> st.cra[7:0] == st.cra[15:8])
    else $error("repeat counter not reloaded");
  a_unit_writeback: assert property (s_unit_done |=> s_writeback)
    else $error("no write back after transfer");
  a_chain_stride: assert property (chain_go |=> st.fsm == etc_pkg::S_FETCH &&
    st.info_addr == $past(st.info_addr) + etc_pkg::INFO_STRIDE)
    else $error("chained set address wrong");
endmodule // etc_core

// >>> pkg/etc_pkg.sv
// constants, types and state layout for the event transfer controller
package etc_pkg;
  // register byte offsets on the apb side
  localparam logic [7:0] OFS_EN_FIRST = 8'h00;
  localparam logic [7:0] OFS_EN_LAST = 8'h10;
  localparam logic [7:0] OFS_CSR = 8'h14;
  localparam logic [7:0] OFS_BASE = 8'h18;
  // control/status bit positions
  localparam int BIT_NMI = 10;
  localparam int BIT_AE = 9;
  localparam int BIT_SWDE = 8;
  // reset values
  localparam logic [7:0] EN_RESET = 8'h00;
  localparam logic [7:0] VEC_RESET = 8'h00;
  // vector table base and information set stride
  localparam logic [15:0] VEC_BASE = 16'h0400;
  localparam logic [31:0] INFO_STRIDE = 32'h0000_0010;
  localparam logic [5:0] SRC_TOP = 6'h27;
  // mode word field positions
  localparam int MODE_SM = 14;
  localparam int MODE_DM = 12;
  localparam int MODE_MD = 10;
  localparam int MODE_SZ = 8;
  localparam int MODE_DTS = 7;
  localparam int MODE_CHAIN_ENABLE = 6;
  localparam int MODE_DISEL = 5;
  localparam int MODE_CONTINUE_ON_NMI = 4;
  localparam logic [1:0] MD_NORMAL = 2'h0;
  localparam logic [1:0] MD_REPEAT = 2'h1;
  localparam logic [1:0] MD_BLOCK = 2'h2;
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_LONG = 2'h2;

  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_VEC = 6'h02,
    S_FETCH = 6'h04,
    S_XREAD = 6'h08,
    S_XWRITE = 6'h10,
    S_WBACK = 6'h20
  } etc_fsm_e;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } etc_apb_s;

  typedef struct packed {
    logic req;
    logic we;
    logic [1:0] size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } etc_mem_s;

  typedef struct packed {
    etc_fsm_e fsm;
    logic [4:0][7:0] en;
    logic [4:0][7:0] en_seen;
    logic nmi;
    logic ae;
    logic swde;
    logic [7:0] vec;
    logic [2:0] csr_seen;
    logic [31:0] prdata;
    etc_mem_s mem;
    logic [31:0] info_addr;
    logic [15:0] mode;
    logic [15:0] cra;
    logic [31:0] sar;
    logic [31:0] dar;
    logic [31:0] iar;
    logic [16:0] blk_left;
    logic [31:0] dbuf;
    logic [1:0] widx;
    logic sw_run;
  } etc_state_s;
endpackage

// >>> testbench/etc_mem_model.sv
// memory and vector table model on the far side of the transfer engine
module etc_mem_model (
  input wire logic clk_in,
  input wire etc_pkg::etc_mem_s mem_in,
  input wire logic [1:0] wait_in,
  input wire logic [31:0] err_addr_in,
  output logic ack_out,
  output logic err_out,
  output logic [31:0] rdata_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] mem [logic [29:0]];
  logic [1:0] cnt;
  logic [31:0] w;
  logic [31:0] m;
  logic [4:0] sh;

  // quiet start
  initial begin
    ack_out = 1'b0;
    err_out = 1'b0;
    rdata_out = 32'h0;
    cnt = 2'h0;
  end

  // answer each held request after wait_in idle cycles
  always @(posedge clk_in) begin
    sh = {mem_in.addr[1:0], 3'b000};
    m = (mem_in.size == 2'h0) ? 32'hff : (mem_in.size == 2'h1) ? 32'hffff : 32'hffff_ffff;
    w = mem.exists(mem_in.addr[31:2]) ? mem[mem_in.addr[31:2]] : 32'h0;
    if (ack_out || !mem_in.req) begin
      ack_out <= 1'b0;
      err_out <= 1'b0;
      rdata_out <= ~rdata_out;  // released data does not hold
      cnt <= 2'h0;
    end else if (cnt != wait_in) begin
      cnt <= cnt + 2'h1;
    end else begin
      ack_out <= 1'b1;
      err_out <= (mem_in.addr == err_addr_in);
      rdata_out <= (w >> sh) & m;
      if (mem_in.we && mem_in.addr != err_addr_in) begin
        mem[mem_in.addr[31:2]] = (w & ~(m << sh)) | ((mem_in.wdata & m) << sh);
      end
    end
  end
endmodule  // etc_mem_model

// >>> testbench/event_transfer_controller_regs_bench.sv
// self-checking bench for the event transfer controller
module event_transfer_controller_regs_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_in;
  logic rst_in;
  logic standby_in;
  logic nmi_in;
  etc_pkg::etc_apb_s apb;
  logic pready;
  logic pslverr;
  logic [31:0] prdata;
  logic [39:0] src_req;
  logic [39:0] src_ack;
  etc_pkg::etc_mem_s mem;
  logic mem_ack;
  logic mem_err;
  logic [31:0] mem_rdata;
  logic busy;
  logic [1:0] wait_sel;
  logic [31:0] err_addr;
  int err_count;
  int compares;

  etc_core uut (.clk_in(clk_in), .rst_in(rst_in), .standby_in(standby_in), .nmi_in(nmi_in),
    .apb_in(apb), .pready_out(pready), .pslverr_out(pslverr), .prdata_out(prdata),
    .src_req_in(src_req), .src_ack_out(src_ack), .mem_out(mem), .mem_ack_in(mem_ack),
    .mem_err_in(mem_err), .mem_rdata_in(mem_rdata), .busy_out(busy));

  etc_mem_model mm (.clk_in(clk_in), .mem_in(mem), .wait_in(wait_sel),
    .err_addr_in(err_addr), .ack_out(mem_ack), .err_out(mem_err), .rdata_out(mem_rdata));

  // 200 MHz clock
  always #2.5 clk_in = ~clk_in;

  task automatic close_out();
    if (err_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  // one apb transfer, entered just after a rising edge
  task automatic apb_io(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
    int n;
    n = 0;
    apb <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk_in);
    apb.penable <= 1'b1;
    @(posedge clk_in);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge clk_in);
      n++;
    end
    chk("pready", 32'h1, {31'h0, pready});
    q = prdata;
    e = pslverr;
    apb <= '0;
    @(posedge clk_in);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb_io(1'b1, a, d, q, e);
  endtask

  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic e;
    apb_io(1'b0, a, 32'h0, q, e);
    chk(n, x, q);
  endtask

  function automatic logic [31:0] get(input logic [31:0] a);
    return mm.mem[a[31:2]];
  endfunction

  task automatic info(input logic [31:0] a, input logic [31:0] w0, w1, w2, w3);
    mm.mem[a[31:2]] = w0;
    mm.mem[a[31:2] + 30'h1] = w1;
    mm.mem[a[31:2] + 30'h2] = w2;
    mm.mem[a[31:2] + 30'h3] = w3;
  endtask

  // wait for the engine to return idle
  task automatic idle();
    int n;
    n = 0;
    @(posedge clk_in);
    while (busy !== 1'b0 && n < 2000) begin
      @(posedge clk_in);
      n++;
    end
    chk("busy", 32'h0, {31'h0, busy});
  endtask

  // raise a source request and see whether it is taken
  task automatic kick(input int s, input logic x);
    logic seen;
    seen = 1'b0;
    src_req[s] <= 1'b1;
    for (int n = 0; n < 20 && !seen; n++) begin
      @(posedge clk_in);
      seen = (src_ack[s] === 1'b1);
    end
    src_req[s] <= 1'b0;
    chk("source taken", {31'h0, x}, {31'h0, seen});
    idle();
  endtask

  task automatic t_regs();
    logic [31:0] q;
    logic e;
    for (int i = 0; i < 5; i++) begin
      rdc("enable reset", 8'(4 * i), 32'h0);
      wr(8'(4 * i), 32'hff);
      wr(8'(4 * i), 32'h00);
      rdc("enable set", 8'(4 * i), 32'hff);
    end
    wr(8'h04, 32'h00);
    rdc("enable cleared", 8'h04, 32'h0);
    rdc("status reset", etc_pkg::OFS_CSR, 32'h0);
    apb_io(1'b0, 8'h1c, 32'h0, q, e);
    chk("unmapped error", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, q);
    wr(etc_pkg::OFS_BASE, 32'h0001);
    rdc("base", etc_pkg::OFS_BASE, 32'h0001);
  endtask

  task automatic t_norm();
    mm.mem[30'h100] = 32'h0100;
    info(32'h0001_0100, 32'ha100_0000, 32'h2000, 32'h3000, 32'h0);
    mm.mem[30'h800] = 32'h5a5a;
    wait_sel <= 2'h2;
    kick(39, 1'b1);
    wait_sel <= 2'h0;
    chk("normal count", 32'ha100_ffff, get(32'h0001_0100));
    chk("source step", 32'h2002, get(32'h0001_0104));
    chk("dest step", 32'h3002, get(32'h0001_0108));
    chk("data moved", 32'h5a5a, get(32'h3000));
  endtask

  task automatic t_rep();
    logic [15:0] cin [2] = '{16'h0301, 16'h0300};
    logic [15:0] cout [2] = '{16'h0303, 16'h03ff};
    logic [31:0] dout [2] = '{32'h3000, 32'h3008};
    for (int i = 0; i < 2; i++) begin
      info(32'h0001_0100, {16'ha600, cin[i]}, 32'h2000, 32'h3004, 32'h3000);
      kick(39, 1'b1);
      chk("repeat count", {16'ha600, cout[i]}, get(32'h0001_0100));
      chk("repeat dest", dout[i], get(32'h0001_0108));
    end
  endtask

  task automatic t_blk();
    mm.mem[30'h800] = 32'h4433_2211;
    info(32'h0001_0100, 32'ha800_0002, 32'h2000, 32'h3100, 32'h0003);
    kick(39, 1'b1);
    chk("block count", 32'ha800_0001, get(32'h0001_0100));
    chk("block source", 32'h2003, get(32'h0001_0104));
    chk("block data", 32'h0033_2211, get(32'h3100));
  endtask

  task automatic t_chain();
    info(32'h0001_0100, 32'ha140_0005, 32'h2000, 32'h3200, 32'h0);
    info(32'h0001_0110, 32'ha100_0001, 32'h2000, 32'h3204, 32'h0);
    wait_sel <= 2'h1;
    kick(39, 1'b1);
    wait_sel <= 2'h0;
    chk("first set", 32'ha140_0004, get(32'h0001_0100));
    chk("second set", 32'ha100_0000, get(32'h0001_0110));
    chk("second data", 32'h2211, get(32'h3204));
  endtask

  // nmi arrives with the request: block stops early unless continue-on-nmi
  task automatic t_nmi();
    logic [15:0] md [2] = '{16'ha800, 16'ha810};
    logic [31:0] sx [2] = '{32'h2001, 32'h2003};
    for (int i = 0; i < 2; i++) begin
      info(32'h0001_0100, {md[i], 16'h0002}, 32'h2000, 32'h3400, 32'h0003);
      src_req[39] <= 1'b1;
      nmi_in <= 1'b1;
      @(posedge clk_in);
      src_req[39] <= 1'b0;
      nmi_in <= 1'b0;
      idle();
      chk("nmi count", {md[i], 16'h0001}, get(32'h0001_0100));
      chk("nmi source", sx[i], get(32'h0001_0104));
      rdc("nmi stop flag", etc_pkg::OFS_CSR, 32'h0400);
      wr(etc_pkg::OFS_CSR, 32'h0);
    end
  endtask

  task automatic t_err();
    info(32'h0001_0100, 32'ha100_0001, 32'h2000, 32'h3000, 32'h0);
    err_addr <= 32'h2000;
    kick(39, 1'b1);
    err_addr <= 32'hffff_ffff;
    wr(etc_pkg::OFS_CSR, 32'h0);
    rdc("error flag", etc_pkg::OFS_CSR, 32'h0200);
    kick(39, 1'b0);
    wr(etc_pkg::OFS_CSR, 32'h0);
    rdc("error cleared", etc_pkg::OFS_CSR, 32'h0);
  endtask

  task automatic t_sw();
    nmi_in <= 1'b1;
    @(posedge clk_in);
    nmi_in <= 1'b0;
    rdc("nmi flag", etc_pkg::OFS_CSR, 32'h0400);
    wr(etc_pkg::OFS_CSR, 32'h0508);
    rdc("soft enable", etc_pkg::OFS_CSR, 32'h0508);
    wr(etc_pkg::OFS_CSR, 32'h050a);
    rdc("vector locked", etc_pkg::OFS_CSR, 32'h0508);
    kick(39, 1'b0);
    mm.mem[30'h102] = 32'h0200;
    info(32'h0001_0200, 32'ha100_0003, 32'h2000, 32'h3300, 32'h0);
    wr(etc_pkg::OFS_CSR, 32'h0108);
    idle();
    chk("soft transfer", 32'ha100_0002, get(32'h0001_0200));
    rdc("soft done", etc_pkg::OFS_CSR, 32'h0008);
  endtask

  task automatic t_stby();
    wr(etc_pkg::OFS_CSR, 32'h0010);
    standby_in <= 1'b1;
    @(posedge clk_in);
    standby_in <= 1'b0;
    rdc("standby enable", 8'h00, 32'h0);
    rdc("standby status", etc_pkg::OFS_CSR, 32'h0);
    rdc("standby base", etc_pkg::OFS_BASE, 32'h0001);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    rdc("reset base", etc_pkg::OFS_BASE, 32'h0001);
  endtask

  // main sequence
  initial begin
    clk_in = 1'b0;
    rst_in = 1'b1;
    standby_in = 1'b0;
    nmi_in = 1'b0;
    apb = '0;
    src_req = '0;
    wait_sel = 2'h0;
    err_addr = 32'hffff_ffff;
    err_count = 0;
    compares = 0;
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    t_regs();
    t_norm();
    t_rep();
    t_blk();
    t_chain();
    t_nmi();
    t_err();
    t_sw();
    t_stby();
    close_out();
  end

  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk_in);
    err_count++;
    close_out();
  end
endmodule  // event_transfer_controller_regs_bench
